// file: hdl/rbt_xcvr.sv
// Registered two-half bus transceiver with APB control
//
// Function
// - Two independent eight-lane halves, own controls
// - Capture clocks store their bus on rising edge
// - Capture never gated by enables or selects
// - B drivers on when enable is high
// - A drivers on when enable is low
// - B follows live A when select low
// - B driven from A store when select high
// - A follows live B when select low
// - A driven from B store when select high
// - Isolation: both inputs, registers still capture
// - Real-time A to B: both registers get A
// - Real-time B to A: both registers get B
// - Both stored and driven: contents cross over
// - Both real-time driven: lanes hold their value
// - Undriven lanes keep their last level
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Operating summary, per half, control word bits as in the package
//
// Drive enables
//   b_drive_enable high        : half drives its B lanes
//   a_drive_enable_low low     : half drives its A lanes
//   Both off                   : isolation, both buses are inputs
//
// Source selects
//   a_to_b_source_select low   : B carries the live A level
//   a_to_b_source_select high  : B carries the A store
//   b_to_a_source_select low   : A carries the live B level
//   b_to_a_source_select high  : A carries the B store
//
// Capture clocks
//   Each is a control bit; a write taking it from 0 to 1 is one edge
//   Capture ignores enables and selects, so isolation still stores
//   Software must write 0 then 1 again for each further capture
//
// Special combinations
//   Both driving, both live    : lanes hold their own level
//   Both driving, both stored  : the two stores cross over
//   Real-time one way, both clocks rising: both stores get one value
//
// Timing
//   Lane outputs are registered: a live path lags its input by one
//   pclk, the price of every pin coming straight from a flop
//   A capture lands one pclk edge after the writing APB edge
//   The stores have no reset and read unknown until captured
//
// Reset
//   Control returns to isolation, lane flops and keepers clear to zero
//   The stores keep whatever they held: they have no reset at all
//
// Limitations
//   Contention is not detected: partners must release first
//   The keeper is a flop standing in for a weak hold circuit
//   Half 1 sits at the next word; halves never share a control bit
////////////////////////////////////////////////////////////////////////////

module rbt_xcvr
    import rbt_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [RBT_ADDR_W-1:0] paddr,
    input  wire logic [RBT_DATA_W-1:0] pwdata,
    output logic      [RBT_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // A bus lanes
    input  wire logic [RBT_WIDTH-1:0]  a_bus_lane_i,
    input  wire logic [RBT_WIDTH-1:0]  a_bus_lane_ext_oe,
    output logic      [RBT_WIDTH-1:0]  a_bus_lane_o,
    output logic      [RBT_WIDTH-1:0]  a_bus_lane_oe,
    output logic      [RBT_WIDTH-1:0]  a_bus_lane_hold,
    // B bus lanes
    input  wire logic [RBT_WIDTH-1:0]  b_bus_lane_i,
    input  wire logic [RBT_WIDTH-1:0]  b_bus_lane_ext_oe,
    output logic      [RBT_WIDTH-1:0]  b_bus_lane_o,
    output logic      [RBT_WIDTH-1:0]  b_bus_lane_oe,
    output logic      [RBT_WIDTH-1:0]  b_bus_lane_hold
);

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic                  pready_r;
    logic                  pslverr_r;
    logic [RBT_DATA_W-1:0] prdata_r;

    // Access phase is always the cycle after setup: one fixed wait-free
    // answer keeps the slave simple and its timing predictable
    wire setup_w    = psel & ~penable;
    wire access_w   = psel & penable & pready_r;
    wire wr_take_w  = access_w & pwrite;

    // Full-address match only: an alias would let a stray write land
    // on a control word and switch drivers without warning
    wire hit_ctrl0  = (paddr == RBT_CTRL0_OFF);
    wire hit_ctrl1  = (paddr == RBT_CTRL1_OFF);
    wire hit_store  = (paddr == RBT_STORE_OFF);
    wire hit_lanes  = (paddr == RBT_LANES_OFF);
    wire hit_mode   = (paddr == RBT_MODE_OFF);
    wire hit_any    = hit_ctrl0 | hit_ctrl1 | hit_store | hit_lanes
                    | hit_mode;

    ////////////////////////////////////////////////////////////////////////
    // Per-half state

    // One entry per half; the halves share only the APB port
    rbt_ctrl_type    ctrl_r     [RBT_HALVES];
    logic            a_clk_d_r  [RBT_HALVES];
    logic            b_clk_d_r  [RBT_HALVES];
    logic [7:0]      a_store_r  [RBT_HALVES];
    logic [7:0]      b_store_r  [RBT_HALVES];
    logic [7:0]      a_out_r    [RBT_HALVES];
    logic [7:0]      b_out_r    [RBT_HALVES];
    logic [7:0]      a_oe_r     [RBT_HALVES];
    logic [7:0]      b_oe_r     [RBT_HALVES];
    logic [7:0]      a_keep_r   [RBT_HALVES];
    logic [7:0]      b_keep_r   [RBT_HALVES];
    rbt_mode_type    mode_w     [RBT_HALVES];
    logic [RBT_CTRL_W-1:0] ctrl_rd_w [RBT_HALVES];

    logic [RBT_WIDTH-1:0] a_store_all;
    logic [RBT_WIDTH-1:0] b_store_all;
    logic [RBT_WIDTH-1:0] a_keep_all;
    logic [RBT_WIDTH-1:0] b_keep_all;
    logic [RBT_HALVES*RBT_MODE_W-1:0] mode_all;

    genvar h;
    generate
        for (h = 0; h < RBT_HALVES; h++) begin : g_half
            // Per-half data path
            //   a_pin / b_pin : what the lane carries without our drive
            //   a_src / b_src : what we would put on the lane
            //   a_eff / b_eff : what the lane carries, our drive first
            //   Captures and the keeper both take the _eff level, so a
            //   store holds what a probe on the pin would show, save on a live drive, which the pin shows one pclk later
            // Pin slices of this half; each half is blind to the other
            wire [7:0] a_in   = a_bus_lane_i[h*RBT_LANES +: RBT_LANES];
            wire [7:0] a_ext  = a_bus_lane_ext_oe[h*RBT_LANES +: RBT_LANES];
            wire [7:0] b_in   = b_bus_lane_i[h*RBT_LANES +: RBT_LANES];
            wire [7:0] b_ext  = b_bus_lane_ext_oe[h*RBT_LANES +: RBT_LANES];

            // Control decode of this half
            wire hit_me   = (paddr == RBT_CTRL0_OFF
                            + RBT_CTRL_STEP * 12'(h));
            wire b_on     = ctrl_r[h].b_drive_enable;
            wire a_on     = ~ctrl_r[h].a_drive_enable_low;
            wire sel_ab   = ctrl_r[h].a_to_b_source_select;
            wire sel_ba   = ctrl_r[h].b_to_a_source_select;
            wire a_rise   = ctrl_r[h].a_capture_clock & ~a_clk_d_r[h];
            wire b_rise   = ctrl_r[h].b_capture_clock & ~b_clk_d_r[h];

            // Level seen on a lane nobody else drives comes from the keeper
            wire [7:0] a_pin = (a_ext & a_in) | (~a_ext & a_keep_r[h]);
            wire [7:0] b_pin = (b_ext & b_in) | (~b_ext & b_keep_r[h]);

            // Both directions live would loop; each lane holds its level
            wire hold_w = a_on & b_on & ~sel_ab & ~sel_ba;

            // Source for each direction, stored or live
            // On hold each lane replays its own last level from the
            // keeper, not the opposite bus, so the sides never trade
            wire [7:0] b_src = hold_w ? b_keep_r[h] :
                               sel_ab ? a_store_r[h] :
                                        a_pin;
            wire [7:0] a_src = hold_w ? a_keep_r[h] :
                               sel_ba ? b_store_r[h] :
                                        b_pin;

            // Bus level as it stands, our drive taking precedence
            wire [7:0] a_eff = a_on ? a_src : a_pin;
            wire [7:0] b_eff = b_on ? b_src : b_pin;

            // Control register, written only in the access phase;
            // a setup cycle alone never disturbs the lanes
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_r[h] <= RBT_CTRL_RST;
                end else if (wr_take_w && hit_me) begin
                    ctrl_r[h] <= rbt_ctrl_type'(pwdata[RBT_CTRL_W-1:0]);
                end
            end

            // Previous capture clock levels for edge detection; reset
            // low like the control bits, so reset makes no false edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    a_clk_d_r[h] <= 1'b0;
                    b_clk_d_r[h] <= 1'b0;
                end else begin
                    a_clk_d_r[h] <= ctrl_r[h].a_capture_clock;
                    b_clk_d_r[h] <= ctrl_r[h].b_capture_clock;
                end
            end

            // Storage has no reset: stays unknown until first capture
            always_ff @(posedge pclk) begin
                if (a_rise) begin
                    a_store_r[h] <= a_eff;
                end
            end

            // B side store, independent of the A side clock
            always_ff @(posedge pclk) begin
                if (b_rise) begin
                    b_store_r[h] <= b_eff;
                end
            end

            // Lane drivers, registered so every pin comes from a flop;
            // value and enable move on one edge, never a new enable
            // with an old value
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    a_out_r[h] <= 8'h00;
                    b_out_r[h] <= 8'h00;
                    a_oe_r[h]  <= 8'h00;
                    b_oe_r[h]  <= 8'h00;
                end else begin
                    a_out_r[h] <= a_src;
                    b_out_r[h] <= b_src;
                    a_oe_r[h]  <= {8{a_on}};
                    b_oe_r[h]  <= {8{b_on}};
                end
            end

            // Bus keeper follows whatever level the lane carries; its
            // zero after reset stands in for an unknown hold level
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    a_keep_r[h] <= 8'h00;
                    b_keep_r[h] <= 8'h00;
                end else begin
                    a_keep_r[h] <= a_eff;
                    b_keep_r[h] <= b_eff;
                end
            end

            // Status and read-back packing, decoded from the live
            // control word so it never lags what the lanes do
            assign mode_w[h].a_driving   = a_on;
            assign mode_w[h].b_driving   = b_on;
            assign mode_w[h].static_hold = hold_w;
            assign mode_w[h].exchange    = a_on & b_on & sel_ab & sel_ba;
            assign ctrl_rd_w[h]          = ctrl_r[h];

            assign a_store_all[h*RBT_LANES +: RBT_LANES] = a_store_r[h];
            assign b_store_all[h*RBT_LANES +: RBT_LANES] = b_store_r[h];
            assign a_keep_all[h*RBT_LANES +: RBT_LANES]  = a_keep_r[h];
            assign b_keep_all[h*RBT_LANES +: RBT_LANES]  = b_keep_r[h];
            assign mode_all[h*RBT_MODE_W +: RBT_MODE_W]  = mode_w[h];

            // Pins straight from the flops
            assign a_bus_lane_o[h*RBT_LANES +: RBT_LANES]    = a_out_r[h];
            assign b_bus_lane_o[h*RBT_LANES +: RBT_LANES]    = b_out_r[h];
            assign a_bus_lane_oe[h*RBT_LANES +: RBT_LANES]   = a_oe_r[h];
            assign b_bus_lane_oe[h*RBT_LANES +: RBT_LANES]   = b_oe_r[h];
            assign a_bus_lane_hold[h*RBT_LANES +: RBT_LANES] = a_keep_r[h];
            assign b_bus_lane_hold[h*RBT_LANES +: RBT_LANES] = b_keep_r[h];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data selection
    //
    // Register map, one aligned word each
    //   CTRL0  half 0 control word, read/write
    //   CTRL1  half 1 control word, read/write
    //   STORE  A stores in the low half, B stores in the high half
    //   LANES  keeper levels, same layout as STORE
    //   MODE   four status bits per half:
    //          a_driving, b_driving, static_hold, exchange
    //   Writes to the read-only words are dropped without error;
    //   any other address answers with pslverr and reads zero
    //   Unused upper bits of every word read as zero

    rbt_pair_type store_word;
    rbt_pair_type lanes_word;

    assign store_word.a = a_store_all;
    assign store_word.b = b_store_all;
    assign lanes_word.a = a_keep_all;
    assign lanes_word.b = b_keep_all;

    // Unused bits above each field read as zero
    wire [RBT_DATA_W-1:0] rd_ctrl0 = {26'h0, ctrl_rd_w[0]};
    wire [RBT_DATA_W-1:0] rd_ctrl1 = {26'h0, ctrl_rd_w[1]};
    wire [RBT_DATA_W-1:0] rd_mode  = {24'h0, mode_all};

    wire [RBT_DATA_W-1:0] rd_data_w =
        hit_ctrl0 ? rd_ctrl0 :
        hit_ctrl1 ? rd_ctrl1 :
        hit_store ? store_word :
        hit_lanes ? lanes_word :
        hit_mode  ? rd_mode :
                    32'h0;

    ////////////////////////////////////////////////////////////////////////
    // APB answer: ready and data set up during the setup cycle.
    // Every transfer takes exactly one access cycle; read data is
    // held only while pready stands and is zero otherwise, so a
    // master must take it at the edge that samples pready high

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup_w;
            pslverr_r <= setup_w & ~hit_any;   // Unmapped address only
            // Store word may read unknown before first capture
            prdata_r  <= (setup_w & ~pwrite) ? rd_data_w : 32'h0;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;

endmodule : rbt_xcvr

// file: hdl/rbt_pkg.sv
// Constants, field layouts and carrier types of the registered transceiver
package rbt_pkg;

    // Lane geometry: two independent halves of eight lanes
    localparam int RBT_HALVES = 2;
    localparam int RBT_LANES  = 8;
    localparam int RBT_WIDTH  = RBT_HALVES * RBT_LANES;

    // APB geometry
    localparam int RBT_ADDR_W = 12;
    localparam int RBT_DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] RBT_CTRL0_OFF = 12'h000;
    localparam logic [11:0] RBT_CTRL1_OFF = 12'h004;
    localparam logic [11:0] RBT_STORE_OFF = 12'h008;
    localparam logic [11:0] RBT_LANES_OFF = 12'h00c;
    localparam logic [11:0] RBT_MODE_OFF  = 12'h010;
    localparam logic [11:0] RBT_CTRL_STEP = 12'h004;

    // Per-half control word, bit 0 is b_drive_enable
    typedef struct packed {
        logic b_capture_clock;
        logic a_capture_clock;
        logic b_to_a_source_select;
        logic a_to_b_source_select;
        logic a_drive_enable_low;
        logic b_drive_enable;
    } rbt_ctrl_type;

    localparam int           RBT_CTRL_W   = 6;
    // Reset leaves both sides undriven: isolation
    localparam rbt_ctrl_type RBT_CTRL_RST = rbt_ctrl_type'(6'h02);

    // Per-half mode status, four bits per half in the mode register
    typedef struct packed {
        logic exchange;
        logic static_hold;
        logic b_driving;
        logic a_driving;
    } rbt_mode_type;

    localparam int RBT_MODE_W = 4;

    // Word layout of the store and lane registers
    typedef struct packed {
        logic [15:0] b;
        logic [15:0] a;
    } rbt_pair_type;

endpackage : rbt_pkg

// file: sim/rbt_xcvr_props.sv
// Port-level property checker for the registered transceiver
`timescale 1ns/1ns
module rbt_xcvr_props
    import rbt_pkg::*;
(
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [RBT_ADDR_W-1:0] paddr,
    input wire logic [RBT_DATA_W-1:0] pwdata,
    input wire logic                  pready,
    // Lanes
    input wire logic [RBT_WIDTH-1:0]  a_bus_lane_i,
    input wire logic [RBT_WIDTH-1:0]  a_bus_lane_ext_oe,
    input wire logic [RBT_WIDTH-1:0]  a_bus_lane_o,
    input wire logic [RBT_WIDTH-1:0]  a_bus_lane_oe,
    input wire logic [RBT_WIDTH-1:0]  b_bus_lane_i,
    input wire logic [RBT_WIDTH-1:0]  b_bus_lane_ext_oe,
    input wire logic [RBT_WIDTH-1:0]  b_bus_lane_o,
    input wire logic [RBT_WIDTH-1:0]  b_bus_lane_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr_w;
    logic [5:0] ctl_r;
    logic [2:0] quiet_r;
    // Completed write to the half-0 control word
    assign wr_w = psel & penable & pready & pwrite
                & (paddr == RBT_CTRL0_OFF);
    // Control shadow; quiet count lets stored outputs settle first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r   <= 6'h02;
            quiet_r <= 3'h0;
        end else if (wr_w) begin
            ctl_r   <= pwdata[5:0];
            quiet_r <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    ////////////////
    chk_ready_pulse: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
    chk_b_oe_level: assert property (
        b_bus_lane_oe[7:0] == {8{$past(ctl_r[0])}})
        else $error("B drive enable wrong");
    chk_a_oe_low: assert property (
        a_bus_lane_oe[7:0] == {8{!$past(ctl_r[1])}})
        else $error("A drive enable wrong");
    chk_b_follows_a: assert property (
        $past(ctl_r[2:0]) == 3'b011 && &$past(a_bus_lane_ext_oe[7:0])
        |-> b_bus_lane_o[7:0] == $past(a_bus_lane_i[7:0]))
        else $error("B lanes miss live A");
    chk_a_follows_b: assert property (
        $past(ctl_r[3:0] & 4'hb) == 4'h0 && &$past(b_bus_lane_ext_oe[7:0])
        |-> a_bus_lane_o[7:0] == $past(b_bus_lane_i[7:0]))
        else $error("A lanes miss live B");
    chk_b_stored: assert property (
        quiet_r > 3'h3 && (ctl_r & 6'h05) == 6'h05
        |-> $stable(b_bus_lane_o[7:0]))
        else $error("Stored B drive moved");
    chk_a_stored: assert property (
        quiet_r > 3'h3 && (ctl_r & 6'h0a) == 6'h08
        |-> $stable(a_bus_lane_o[7:0]))
        else $error("Stored A drive moved");
    chk_static_hold: assert property (
        quiet_r > 3'h3 && ctl_r[3:0] == 4'h1
        |-> $stable(a_bus_lane_o[7:0]) && $stable(b_bus_lane_o[7:0]))
        else $error("Held lanes moved");
endmodule : rbt_xcvr_props

bind rbt_xcvr rbt_xcvr_props rbt_xcvr_props_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .a_bus_lane_i, .a_bus_lane_ext_oe, .a_bus_lane_o, .a_bus_lane_oe,
    .b_bus_lane_i, .b_bus_lane_ext_oe, .b_bus_lane_o, .b_bus_lane_oe
);

// file: sim/rbt_bus_partner.sv
// Behavioural parallel bus partner on one side of the transceiver
`timescale 1ns/1ns
module rbt_bus_partner
    import rbt_pkg::*;
(
    // Bench requests
    input  wire logic [RBT_WIDTH-1:0] want,
    input  wire logic [RBT_WIDTH-1:0] value,
    // Transceiver side
    input  wire logic [RBT_WIDTH-1:0] dut_oe,
    output logic      [RBT_WIDTH-1:0] lane,
    output logic      [RBT_WIDTH-1:0] ext_oe
);
    // Back off wherever the transceiver drives
    assign ext_oe = want & ~dut_oe;
    // Released lanes show the inverse, never a stale copy
    assign lane = (value & ext_oe) | (~value & ~ext_oe);
endmodule : rbt_bus_partner

// file: sim/rbt_xcvr_tb.sv
// Self-checking bench for the registered transceiver
`timescale 1ns/1ns
module rbt_xcvr_tb
    import rbt_pkg::*;
;
    logic                  pclk    = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel    = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [RBT_ADDR_W-1:0] paddr   = 12'h000;
    logic [RBT_DATA_W-1:0] pwdata  = 32'h0;
    logic [RBT_DATA_W-1:0] prdata, rd;
    logic                  pready, pslverr, er;
    logic [RBT_WIDTH-1:0]  a_i, a_xoe, a_o, a_oe, a_want, a_val, a_hold;
    logic [RBT_WIDTH-1:0]  b_i, b_xoe, b_o, b_oe, b_want, b_val, b_hold;
    int                    failures = 0;
    int                    checked  = 0;
    int                    cyc      = 0;
    rbt_xcvr rbt_xcvr_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr,
        .a_bus_lane_i(a_i), .a_bus_lane_ext_oe(a_xoe), .a_bus_lane_o(a_o),
        .a_bus_lane_oe(a_oe), .a_bus_lane_hold(a_hold),
        .b_bus_lane_i(b_i), .b_bus_lane_ext_oe(b_xoe), .b_bus_lane_o(b_o),
        .b_bus_lane_oe(b_oe), .b_bus_lane_hold(b_hold));
    rbt_bus_partner rbt_bus_partner_a (.want(a_want), .value(a_val),
        .dut_oe(a_oe), .lane(a_i), .ext_oe(a_xoe));
    rbt_bus_partner rbt_bus_partner_b (.want(b_want), .value(b_val),
        .dut_oe(b_oe), .lane(b_i), .ext_oe(b_xoe));
    // 250 MHz clock
    initial forever #2 pclk = ~pclk;
    // Hang guard, far above the 170 or so cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            results();
        end
    end
    ////////////////
    task results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] seen, expv);
        checked++;
        if (seen !== expv) begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, expv, seen);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // One APB transfer; holds until pready is sampled high
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task drv(input logic [7:0] aw, av, bw, bv);
        @(posedge pclk);
        a_want <= {8'h00, aw};
        a_val  <= {8'h00, av};
        b_want <= {8'h00, bw};
        b_val  <= {8'h00, bv};
    endtask : drv
    // Control write; three cycles cover capture and output latency
    task wc(input logic [7:0] v);
        apb(1'b1, RBT_CTRL0_OFF, {24'h0, v});
        tick(3);
    endtask : wc
    task store(input logic [7:0] av, bv);
        apb(1'b0, RBT_STORE_OFF, 32'h0);
        chk("store", {16'h0, rd[23:16], rd[7:0]}, {16'h0, bv, av});
    endtask : store
    ////////////////
    task t_reset();
        apb(1'b0, RBT_CTRL0_OFF, 32'h0);
        chk("ctrl0", rd, 32'h02);
        chk("oe", {a_oe, b_oe}, 32'h0);
    endtask : t_reset
    task t_ab();
        drv(8'hff, 8'h5a, 8'h00, 8'h00);
        wc(8'h03);
        chk("b_oe", {16'h0, b_oe}, 32'h00ff);
        chk("b_o", {24'h0, b_o[7:0]}, 32'h5a);
        drv(8'hff, 8'ha5, 8'h00, 8'h00);
        tick(2);
        chk("b_o", {24'h0, b_o[7:0]}, 32'ha5);
        wc(8'h33);
        store(8'ha5, 8'ha5);
        wc(8'h07);
        drv(8'hff, 8'h3c, 8'h00, 8'h00);
        tick(2);
        chk("b_o", {24'h0, b_o[7:0]}, 32'ha5);
    endtask : t_ab
    task t_ba();
        drv(8'h00, 8'h00, 8'hff, 8'h69);
        wc(8'h00);
        chk("a_oe", {16'h0, a_oe}, 32'h00ff);
        chk("a_o", {24'h0, a_o[7:0]}, 32'h69);
        wc(8'h30);
        store(8'h69, 8'h69);
        wc(8'h08);
        drv(8'h00, 8'h00, 8'hff, 8'h11);
        tick(2);
        chk("a_o", {24'h0, a_o[7:0]}, 32'h69);
    endtask : t_ba
    task t_swap();
        wc(8'h02);
        drv(8'hff, 8'h12, 8'hff, 8'h34);
        wc(8'h32);
        store(8'h12, 8'h34);
        wc(8'h0d);
        chk("xchg", {16'h0, b_o[7:0], a_o[7:0]}, 32'h1234);
        apb(1'b0, RBT_MODE_OFF, 32'h0);
        chk("mode", rd, 32'h0b);
        wc(8'h3d);
        store(8'h34, 8'h12);
        wc(8'h02);
        drv(8'hff, 8'h77, 8'hff, 8'h88);
        wc(8'h12);
        store(8'h77, 8'h12);
        wc(8'h22);
        store(8'h77, 8'h88);
    endtask : t_swap
    task t_hold();
        drv(8'hff, 8'h55, 8'hff, 8'h66);
        wc(8'h01);
        apb(1'b0, RBT_MODE_OFF, 32'h0);
        chk("mode", rd, 32'h07);
        drv(8'hff, 8'haa, 8'hff, 8'hbb);
        tick(4);
        chk("held", {16'h0, b_o[7:0], a_o[7:0]}, 32'h6655);
        wc(8'h02);
        drv(8'h00, 8'h00, 8'h00, 8'h00);
        tick(3);
        apb(1'b0, RBT_LANES_OFF, 32'h0);
        chk("keep", {16'h0, rd[23:16], rd[7:0]}, 32'hbbaa);
        chk("hold", {16'h0, b_hold[7:0], a_hold[7:0]}, 32'hbbaa);
        apb(1'b0, 12'h014, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        chk("rdz", rd, 32'h0);
    endtask : t_hold
    task t_half1();
        @(posedge pclk);
        a_want <= 16'hff00;
        a_val  <= 16'hc300;
        apb(1'b1, RBT_CTRL1_OFF, 32'h03);
        tick(3);
        chk("oe1", {a_oe, b_oe}, 32'h0000ff00);
        chk("b_o1", {24'h0, b_o[15:8]}, 32'hc3);
        apb(1'b0, RBT_MODE_OFF, 32'h0);
        chk("mode1", rd, 32'h20);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        store(8'h77, 8'h88);
        apb(1'b0, RBT_CTRL1_OFF, 32'h0);
        chk("ctrl1", rd, 32'h02);
    endtask : t_half1
    initial begin
        {a_want, a_val, b_want, b_val} = 64'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ab();
        t_ba();
        t_swap();
        t_hold();
        t_half1();
        results();
    end
endmodule : rbt_xcvr_tb
